// [rtl/kpirq_top.sv]
// Keypad dedicated key selection and interrupt status register block
// What this block does
// - Row field bits 15:10, reset all ones
// - Column field bits 9:8, reset ones
// - Column field bits 7:0, reset ones
// - Zero bit makes pin dedicated key
// - Event lost sets on FIFO overflow
// - Event lost cleared only by event-clear
// - Event flag set while FIFO nonempty
// - Event flag clears once FIFO drained
// - Key lost on change with scan pending
// - Key lost when over four keys held
// - Scan flag on changed scan result
// - Scan flag clears after codes read
// - Masked status is raw gated by mask
// - Masked status uses raw bit positions
// - Raw status read-only, resets zero
// - Mask one blocks; defaults 0011
// - Event clear empties FIFO and flags
// - Scan clear drops scan and key lost
// - Reading four key codes clears scan
`timescale 1ns/1ps
module kpirq_top
    import kpirq_pkg::*;
(
    input  wire logic        clk_sys_in,
    input  wire logic        rstn_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [7:0]  reg_wdata_in,
    output logic      [7:0]  reg_rdata_out,
    input  wire logic        fifo_overflow_in,
    input  wire logic        fifo_not_empty_in,
    input  wire logic        key_change_in,
    input  wire logic [2:0]  keys_held_in,
    input  wire logic        scan_done_in,
    input  wire logic        scan_changed_in,
    output logic             fifo_flush_out,
    output logic      [5:0]  row_ded_out,
    output logic      [9:0]  col_ded_out,
    output logic             keypad_irq_out
);
    import kpirq_pkg::*;

    // ==========================================
    // State
    typedef struct packed {
        logic [3:0] mask;
        logic [3:0] codes_read;
        logic [7:0] rdata;
        logic       flush;
    } kpirq_top_t;

    kpirq_top_t r;
    kpirq_top_t next_r;

    logic [15:0] ded_sel;
    logic [3:0]  raw;
    logic [3:0]  masked;
    logic        wr_ded_hi;
    logic        wr_ded_lo;
    logic        clr_event;
    logic        clr_scan;
    logic        codes_done;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    // ==========================================
    // Write decode
    // Dedicated select is 16 bits on a byte bus: high byte at the offset, low byte one above
    assign wr_ded_hi = reg_wr_in && hit(reg_addr_in, OFS_DEDICATED_KEY_SELECT);
    assign wr_ded_lo = reg_wr_in && hit(reg_addr_in, OFS_DEDICATED_KEY_SELECT + 8'h01);
    assign clr_event = reg_wr_in && hit(reg_addr_in, OFS_IRQ_CLEAR)
                       && reg_wdata_in[BIT_CLR_EVENT_FIFO];
    // all four reads act as clear
    assign clr_scan = (reg_wr_in && hit(reg_addr_in, OFS_IRQ_CLEAR)
                       && reg_wdata_in[BIT_CLR_SCAN]) || codes_done;

    // ==========================================
    // Submodules
    kpirq_ded_sel u_ded (
        .clk_sys_in  (clk_sys_in),
        .rstn_in     (rstn_in),
        .wr_hi_in    (wr_ded_hi),
        .wr_lo_in    (wr_ded_lo),
        .wdata_in    (reg_wdata_in),
        .sel_out     (ded_sel),
        .row_ded_out (row_ded_out),
        .col_ded_out (col_ded_out)
    );

    kpirq_flags u_flags (
        .clk_sys_in        (clk_sys_in),
        .rstn_in           (rstn_in),
        .fifo_overflow_in  (fifo_overflow_in),
        .fifo_not_empty_in (fifo_not_empty_in),
        .key_change_in     (key_change_in),
        .keys_held_in      (keys_held_in),
        .scan_done_in      (scan_done_in),
        .scan_changed_in   (scan_changed_in),
        .clr_event_in      (clr_event),
        .clr_scan_in       (clr_scan),
        .raw_out           (raw)
    );

    assign masked = raw & ~r.mask;

    // ==========================================
    // Register file
    always_comb begin
        next_r = r;
        next_r.flush = clr_event;
        codes_done = 1'b0;
        if (reg_wr_in && hit(reg_addr_in, OFS_IRQ_MASK)) begin
            next_r.mask = reg_wdata_in[3:0];
        end
        // Each key code register read marks its slot; a changed scan result restarts the tally
        if (scan_done_in && scan_changed_in) begin
            next_r.codes_read = 4'h0;
        end
        if (reg_rd_in && reg_addr_in >= OFS_KEY_CODE_FIRST
                && reg_addr_in <= OFS_KEY_CODE_LAST) begin
            next_r.codes_read[2'(reg_addr_in - OFS_KEY_CODE_FIRST)] = 1'b1;
        end
        if (&next_r.codes_read) begin
            codes_done = 1'b1;
            next_r.codes_read = 4'h0;
        end
        if (reg_rd_in) begin
            case (reg_addr_in)
                OFS_DEDICATED_KEY_SELECT: begin
                    next_r.rdata = ded_sel[15:8];
                end
                OFS_DEDICATED_KEY_SELECT + 8'h01: begin
                    next_r.rdata = ded_sel[7:0];
                end
                OFS_RAW_IRQ_STATUS: begin
                    next_r.rdata = {4'h0, raw};
                end
                OFS_MASKED_IRQ_STATUS: begin
                    next_r.rdata = {4'h0, masked};
                end
                OFS_IRQ_MASK: begin
                    next_r.rdata = {4'h0, r.mask};
                end
                default: begin
                    next_r.rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            r.mask       <= MASK_RESET;
            r.codes_read <= 4'h0;
            r.rdata      <= 8'h00;
            r.flush      <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    assign reg_rdata_out = r.rdata;
    assign fifo_flush_out = r.flush;
    assign keypad_irq_out = |masked;
endmodule

// [pkg/kpirq_pkg.sv]
// Package of register offsets, field positions and reset values for the keypad status block
package kpirq_pkg;
    localparam logic [7:0]  OFS_DEDICATED_KEY_SELECT = 8'h04;
    localparam logic [7:0]  OFS_RAW_IRQ_STATUS       = 8'h06;
    localparam logic [7:0]  OFS_MASKED_IRQ_STATUS    = 8'h07;
    localparam logic [7:0]  OFS_IRQ_CLEAR            = 8'h08;
    localparam logic [7:0]  OFS_IRQ_MASK             = 8'h09;
    localparam logic [7:0]  OFS_KEY_CODE_FIRST       = 8'h0B;
    localparam logic [7:0]  OFS_KEY_CODE_LAST        = 8'h0E;
    localparam logic [7:0]  OFS_KEY_EVENT_FIFO       = 8'h10;
    localparam int          BIT_EVENT_LOST           = 3;
    localparam int          BIT_KEY_EVENT            = 2;
    localparam int          BIT_KEY_LOST             = 1;
    localparam int          BIT_SCAN                 = 0;
    localparam int          BIT_CLR_EVENT_FIFO       = 1;
    localparam int          BIT_CLR_SCAN             = 0;
    localparam int          ROW_FIELD_HI             = 15;
    localparam int          ROW_FIELD_LO             = 10;
    localparam int          COLHI_FIELD_HI           = 9;
    localparam int          COLHI_FIELD_LO           = 8;
    localparam int          COLLO_FIELD_HI           = 7;
    localparam int          COLLO_FIELD_LO           = 0;
    localparam logic [5:0]  ROW_FIELD_RESET          = 6'h3F;
    localparam logic [1:0]  COLHI_FIELD_RESET        = 2'h3;
    localparam logic [7:0]  COLLO_FIELD_RESET        = 8'hFF;
    localparam logic [3:0]  MASK_RESET               = 4'h3;
    localparam logic [3:0]  FLAGS_RESET              = 4'h0;
    localparam logic [2:0]  MAX_KEYS_HELD            = 3'h4;
    localparam logic [1:0]  KEY_CODE_LAST_IDX        = 2'h3;
    typedef enum logic [1:0] {KPIRQ_IDLE, KPIRQ_RD_LO} kpirq_wr_state_t;
endpackage

// [rtl/kpirq_ded_sel.sv]
// Dedicated key select register and per-pin mode decode
`timescale 1ns/1ps
module kpirq_ded_sel
    import kpirq_pkg::*;
(
    input  wire logic        clk_sys_in,
    input  wire logic        rstn_in,
    input  wire logic        wr_hi_in,
    input  wire logic        wr_lo_in,
    input  wire logic [7:0]  wdata_in,
    output logic      [15:0] sel_out,
    output logic      [5:0]  row_ded_out,
    output logic      [9:0]  col_ded_out
);
    typedef struct packed {
        logic [15:0] sel;
    } kpirq_ded_t;

    kpirq_ded_t r;
    kpirq_ded_t next_r;

    always_comb begin
        next_r = r;
        if (wr_hi_in) begin
            next_r.sel[15:8] = wdata_in;
        end
        if (wr_lo_in) begin
            next_r.sel[7:0] = wdata_in;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            r.sel[ROW_FIELD_HI:ROW_FIELD_LO]     <= ROW_FIELD_RESET;
            r.sel[COLHI_FIELD_HI:COLHI_FIELD_LO] <= COLHI_FIELD_RESET;
            r.sel[COLLO_FIELD_HI:COLLO_FIELD_LO] <= COLLO_FIELD_RESET;
        end else begin
            r <= next_r;
        end
    end

    assign sel_out = r.sel;
    assign row_ded_out = ~r.sel[ROW_FIELD_HI:ROW_FIELD_LO];
    assign col_ded_out = ~{r.sel[COLHI_FIELD_HI:COLHI_FIELD_LO],
                           r.sel[COLLO_FIELD_HI:COLLO_FIELD_LO]};
endmodule

// [rtl/kpirq_flags.sv]
// Keypad interrupt flags, sticky except the key event level, with set-over-clear priority
`timescale 1ns/1ps
module kpirq_flags
    import kpirq_pkg::*;
(
    input  wire logic        clk_sys_in,
    input  wire logic        rstn_in,
    input  wire logic        fifo_overflow_in,
    input  wire logic        fifo_not_empty_in,
    input  wire logic        key_change_in,
    input  wire logic [2:0]  keys_held_in,
    input  wire logic        scan_done_in,
    input  wire logic        scan_changed_in,
    input  wire logic        clr_event_in,
    input  wire logic        clr_scan_in,
    output logic      [3:0]  raw_out
);
    typedef struct packed {
        logic event_lost;
        logic key_lost;
        logic scan;
        logic fifo_cleared;
    } kpirq_flag_t;

    kpirq_flag_t r;
    kpirq_flag_t next_r;
    logic        set_lost;
    logic        set_scan;

    always_comb begin
        next_r = r;
        set_lost = (key_change_in && r.scan) || (keys_held_in > MAX_KEYS_HELD);
        set_scan = scan_done_in && scan_changed_in;
        if (clr_event_in) begin
            next_r.event_lost = 1'b0;
        end
        if (fifo_overflow_in) begin
            next_r.event_lost = 1'b1;
        end
        if (clr_scan_in) begin
            next_r.key_lost = 1'b0;
            next_r.scan     = 1'b0;
        end
        if (set_lost) begin
            next_r.key_lost = 1'b1;
        end
        if (set_scan) begin
            next_r.scan = 1'b1;
        end
        // Hide stale fill level for the cycle the scanner FIFO reacts to the clear
        next_r.fifo_cleared = clr_event_in;
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign raw_out = {r.event_lost,
                      fifo_not_empty_in && !r.fifo_cleared && !clr_event_in,
                      r.key_lost,
                      r.scan};
endmodule

// [tb/kpirq_top_assertions.sv]
// Port checker for the keypad status block
`timescale 1ns/1ps
module kpirq_chk (
    input wire logic       clk_sys_in,
    input wire logic       rstn_in,
    input wire logic       reg_wr_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic       fifo_overflow_in,
    input wire logic       fifo_not_empty_in,
    input wire logic [2:0] keys_held_in,
    input wire logic       scan_done_in,
    input wire logic       scan_changed_in,
    input wire logic       fifo_flush_out,
    input wire logic [5:0] row_ded_out,
    input wire logic [9:0] col_ded_out,
    input wire logic       keypad_irq_out
);
    import kpirq_pkg::*;
    logic [3:0] msk;
    logic       clr_ev;
    assign clr_ev = reg_wr_in && reg_addr_in == OFS_IRQ_CLEAR && reg_wdata_in[1];
    // Mirror of the mask so irq can be tied to its causes
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            msk <= MASK_RESET;
        end else if (reg_wr_in && reg_addr_in == OFS_IRQ_MASK) begin
            msk <= reg_wdata_in[3:0];
        end
    end
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);
    sequence s_clr_ev;
        clr_ev;
    endsequence
    sequence s_flush;
        fifo_flush_out ##1 !fifo_flush_out;
    endsequence
    a_flush_after_clear: assert property (s_clr_ev ##1 !clr_ev |-> s_flush)
        else $error("flush pulse missing");
    a_flush_has_cause: assert property (fifo_flush_out |-> $past(clr_ev))
        else $error("flush without clear");
    a_row_sel_steady: assert property (!$stable(row_ded_out) |->
        $past(reg_wr_in && reg_addr_in == OFS_DEDICATED_KEY_SELECT)) else $error("row moved");
    a_col_sel_steady: assert property (!$stable(col_ded_out) |->
        $past(reg_wr_in && reg_addr_in[7:1] == 7'h02)) else $error("col moved");
    a_scan_sets_irq: assert property (scan_done_in && scan_changed_in && !msk[0] &&
        !reg_wr_in |=> keypad_irq_out) else $error("scan irq missing");
    a_lost_sets_irq: assert property (fifo_overflow_in && !msk[3] && !reg_wr_in
        |=> keypad_irq_out) else $error("event lost irq missing");
    a_many_keys_irq: assert property (keys_held_in > MAX_KEYS_HELD && !msk[1] &&
        !reg_wr_in |=> keypad_irq_out) else $error("key lost irq missing");
    a_event_level_irq: assert property (fifo_not_empty_in && !msk[2] && !clr_ev &&
        !$past(clr_ev) && !$past(clr_ev, 2) |-> keypad_irq_out) else $error("event irq");
    a_all_masked_quiet: assert property (msk == 4'hF |-> !keypad_irq_out)
        else $error("irq while all masked");
endmodule
bind kpirq_top kpirq_chk chk_u (.clk_sys_in, .rstn_in, .reg_wr_in, .reg_addr_in,
    .reg_wdata_in, .fifo_overflow_in, .fifo_not_empty_in, .keys_held_in, .scan_done_in,
    .scan_changed_in, .fifo_flush_out, .row_ded_out, .col_ded_out, .keypad_irq_out);

// [tb/kpirq_host.sv]
// Host model issuing byte strobes on the register port
`timescale 1ns/1ps
module kpirq_host (
    input  wire logic       clk_sys_in,
    input  wire logic [7:0] rdata_in,
    output logic            wr_out,
    output logic            rd_out,
    output logic      [7:0] addr_out,
    output logic      [7:0] wdata_out
);
    initial begin
        wr_out    = 1'b0;
        rd_out    = 1'b0;
        addr_out  = 8'h00;
        wdata_out = 8'h00;
    end
    // Released lines show the inverse so stale values cannot pass
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys_in);
        addr_out  = a;
        wdata_out = d;
        wr_out    = 1'b1;
        @(negedge clk_sys_in);
        wr_out    = 1'b0;
        wdata_out = ~d;
        addr_out  = ~a;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys_in);
        addr_out = a;
        rd_out   = 1'b1;
        @(negedge clk_sys_in);
        rd_out   = 1'b0;
        addr_out = ~a;
        d        = rdata_in;
    endtask
endmodule

// [tb/keypad_dedicated_key_and_irq_status_bench.sv]
// Self-checking bench for the keypad status block
`timescale 1ns/1ps
module keypad_dedicated_key_and_irq_status_bench;
    import kpirq_pkg::*;
    logic       clk_sys_in = 1'b0;
    logic       rstn_in    = 1'b0;
    logic       ov = 1'b0, ne = 1'b0, kc = 1'b0, sd = 1'b0, sc = 1'b0;
    logic [2:0] kh = 3'h0;
    logic       wr, rd, flush, irq;
    logic [7:0] addr, wdata, rdata, r, h, l;
    logic [5:0] row;
    logic [9:0] col;
    int         fails, n_checks, cyc, m_raw, m_mask;
    always #12.5 clk_sys_in = ~clk_sys_in;
    kpirq_top dut_u (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
        .fifo_overflow_in(ov), .fifo_not_empty_in(ne), .key_change_in(kc),
        .keys_held_in(kh), .scan_done_in(sd), .scan_changed_in(sc),
        .fifo_flush_out(flush), .row_ded_out(row), .col_ded_out(col), .keypad_irq_out(irq));
    kpirq_host host_u (.clk_sys_in(clk_sys_in), .rdata_in(rdata), .wr_out(wr),
        .rd_out(rd), .addr_out(addr), .wdata_out(wdata));
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        host_u.rd(a, r);
        chk($sformatf("reg %h", a), {8'h00, r}, {8'h00, exp});
    endtask
    task automatic status();
        rdchk(OFS_RAW_IRQ_STATUS, m_raw[7:0]);
        rdchk(OFS_MASKED_IRQ_STATUS, m_raw[7:0] & ~m_mask[7:0]);
        chk("irq", {15'h0, irq}, {15'h0, |(m_raw[3:0] & ~m_mask[3:0])});
    endtask
    // Scanner side stimulus with the flag model beside it
    task automatic scan(input logic o, e, k, input logic [2:0] kk, input logic d, c);
        @(negedge clk_sys_in);
        {ov, ne, kc, kh, sd, sc} = {o, e, k, kk, d, c};
        // key lost uses the scan flag before this cycle
        if ((k && m_raw[0]) || kk > 3'h4) m_raw |= 4'h2;
        if (o) m_raw |= 4'h8;
        if (d && c) m_raw |= 4'h1;
        m_raw[2] = e;
        @(negedge clk_sys_in);
        {ov, kc, sd} = 3'h0;
    endtask
    task automatic clr(input logic [7:0] d);
        host_u.wr(OFS_IRQ_CLEAR, d);
        chk("flush", {15'h0, flush}, {15'h0, d[1]});
        if (d[1]) m_raw &= ~32'hC;
        if (d[0]) m_raw &= ~32'h3;
    endtask
    always @(posedge clk_sys_in) begin
        cyc++;
        if (cyc == 4000) begin
            fails++;
            final_report();
        end
    end
    initial begin
        m_raw  = 0;
        m_mask = 3;
        void'($urandom(18));
        repeat (10) @(negedge clk_sys_in);
        rstn_in = 1'b1;
        rdchk(8'h04, 8'hFF);
        rdchk(8'h05, 8'hFF);
        rdchk(OFS_IRQ_MASK, 8'h03);
        chk("ded", {row, col}, 16'h0);
        status();
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            h = $urandom;
            l = $urandom;
            host_u.wr(8'h04, h);
            host_u.wr(8'h05, l);
            chk("ded", {row, col}, ~{h, l});
            rdchk(8'h04, h);
            rdchk(8'h05, l);
        end
        host_u.wr(OFS_RAW_IRQ_STATUS, 8'hFF);
        rdchk(8'h30, 8'h00);
        status();
        $display("test select done");
        m_mask = 0;
        host_u.wr(OFS_IRQ_MASK, 8'h00);
        scan(1, 1, 0, 0, 0, 0);
        status();
        clr(8'h01);
        status();
        // host drains pending events before flushing
        host_u.rd(OFS_KEY_EVENT_FIFO, r);
        scan(0, 0, 0, 0, 0, 0);
        status();
        clr(8'h02);
        status();
        $display("test events done");
        scan(0, 0, 0, 0, 1, 0);
        status();
        scan(0, 0, 0, 0, 1, 1);
        status();
        scan(0, 0, 1, 0, 0, 0);
        status();
        clr(8'h01);
        status();
        scan(0, 0, 0, 5, 1, 1);
        scan(0, 0, 0, 0, 0, 0);
        status();
        for (int a = OFS_KEY_CODE_FIRST; a <= OFS_KEY_CODE_LAST; a++) host_u.rd(a[7:0], r);
        m_raw &= ~32'h3;
        status();
        $display("test scan done");
        scan(1, 1, 0, 5, 1, 1);
        for (int i = 0; i < 16; i++) begin
            m_mask = i;
            host_u.wr(OFS_IRQ_MASK, m_mask[7:0]);
            rdchk(OFS_IRQ_MASK, m_mask[7:0]);
            status();
        end
        $display("test mask done");
        final_report();
    end
endmodule
